// ---- rtl/buck_protect_dim_adc.v ----
// Overcurrent persistence, digital dimming delay and converter sequencer
`timescale 1ns/100ps
`default_nettype none
`include "buck_protect_dim_adc_regs.vh"
module buck_protect_dim_adc #(
	parameter PERSIST_W = 2
) (
	input wire clk,
	input wire rst_n,
	input wire [1:0] dimming_control_input,
	input wire [1:0] channel_enable,
	input wire [1:0] buck_period_pulse,
	input wire [1:0] over_limit,
	input wire [PERSIST_W-1:0] overcurrent_persist_count,
	input wire [8:0] forced_sample_interval,
	input wire [7:0] thermal_warning_threshold,
	input wire thermal_shutdown_level_hit,
	output reg [2:0] adc_mux_sel,
	output reg adc_start,
	input wire adc_done,
	input wire [7:0] adc_result,
	input wire rd_en,
	input wire [7:0] rd_addr,
	output reg [8:0] rd_data,
	output reg [1:0] buck_enable,
	output reg [1:0] overcurrent_latched_flag,
	output reg thermal_warning_flag,
	output reg thermal_shutdown_flag
);
	localparam SLOT_CYC = `SLOT_CYC;
	localparam [1:0] SQ_START = 2'h0;
	localparam [1:0] SQ_WAIT = 2'h1;
	localparam [1:0] SQ_NEXT = 2'h2;

	// Odd parity: bit 8 makes the count of ones odd
	function [8:0] with_parity;
		input [7:0] v;
		begin
			with_parity = {~^v, v}; // [RULE_15]
		end
	endfunction

	// Read of one status address; such reads clear latched flags
	function rd_hit;
		input en;
		input [7:0] addr;
		input [7:0] target;
		begin
			rd_hit = en && (addr == target);
		end
	endfunction

	reg [1:0] ctl_s0_q, ctl_s1_q, ctl_s2_q, ctl_q;
	wire [1:0] dly_out;
	reg [1:0] dly_prev_q;
	reg [PERSIST_W:0] oc_cnt_q [0:1];
	reg [1:0] oc_trip_q;
	reg [8:0] res_supply_q, res_boost_q, res_temp_q;
	reg [8:0] res_on_q [0:1];
	reg [8:0] res_str_q [0:1];
	reg [1:0] slot_q;
	reg [1:0] sq_state_q;
	reg [7:0] slot_cnt_q;
	reg [1:0] pend_q;
	reg prio_q;
	reg serve_active_q, serve_ch_q, serve_on_q;
	reg block_q;
	reg [8:0] seq_cnt_q;
	reg forced_q;
	wire [1:0] dim_fall;
	wire [1:0] dim_rise;
	wire seq_end;
	wire pick_ch;
	wire can_serve;

	// Three-stage synchroniser, change accepted when last two agree
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_s0_q <= 2'h0;
			ctl_s1_q <= 2'h0;
			ctl_s2_q <= 2'h0;
			ctl_q <= 2'h0;
		end else begin
			ctl_s0_q <= dimming_control_input;
			ctl_s1_q <= ctl_s0_q;
			ctl_s2_q <= ctl_s1_q;
			ctl_q <= (ctl_s1_q & ctl_s2_q) | (ctl_q & (ctl_s1_q | ctl_s2_q));
		end
	end

	// Per-channel dimming delay and overcurrent persistence
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : chan
			dim_delay_line #(
				.DELAY_CYC(`DIM_DELAY_CYC)
			) u_dly (
				.clk(clk),
				.rst_n(rst_n),
				.level_in(ctl_q[g]),
				.level_out(dly_out[g])
			);

			assign dim_fall[g] = dly_prev_q[g] & ~dly_out[g];
			assign dim_rise[g] = ~dly_prev_q[g] & dly_out[g];

			// Counts over-limit periods and trips at count plus one
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					oc_cnt_q[g] <= {(PERSIST_W+1){1'b0}};
					oc_trip_q[g] <= 1'b0;
					overcurrent_latched_flag[g] <= 1'b0;
				end else begin
					if (oc_trip_q[g]) begin
						oc_cnt_q[g] <= {(PERSIST_W+1){1'b0}};
					end else if (!channel_enable[g] || dim_rise[g]) begin
						oc_cnt_q[g] <= {(PERSIST_W+1){1'b0}}; // [RULE_02]
					end else if (buck_period_pulse[g]) begin
						if (!over_limit[g]) begin
							oc_cnt_q[g] <= {(PERSIST_W+1){1'b0}}; // [RULE_02]
						end else begin
							oc_cnt_q[g] <= oc_cnt_q[g] + 1'b1; // [RULE_01]
						end
					end
					// Trip at persist count plus one, i.e. 1..4 periods [RULE_21]
					if (!oc_trip_q[g] && buck_period_pulse[g] && over_limit[g] &&
						channel_enable[g] && !dim_rise[g] &&
						(oc_cnt_q[g] == {1'b0, overcurrent_persist_count})) begin
						oc_trip_q[g] <= 1'b1; // [RULE_03]
						overcurrent_latched_flag[g] <= 1'b1; // [RULE_20]
					end else if (rd_hit(rd_en, rd_addr, `STATUS_OC_ADDR)) begin
						// Read clears the flag and releases the buck
						oc_trip_q[g] <= 1'b0; // [RULE_04]
						overcurrent_latched_flag[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// Buck enable: delayed dimming level gated by protection
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dly_prev_q <= 2'h0;
			buck_enable <= 2'h0;
		end else begin
			dly_prev_q <= dly_out;
			buck_enable <= dly_out & channel_enable & ~oc_trip_q &
				{2{~thermal_shutdown_flag}}; // [RULE_05] [RULE_03]
		end
	end

	// Thermal flags: warning from the temperature code, shutdown set by thermal_shutdown_level_hit
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			thermal_warning_flag <= 1'b0;
			thermal_shutdown_flag <= 1'b0;
		end else begin
			if (res_temp_q[7:0] >= thermal_warning_threshold) begin
				thermal_warning_flag <= 1'b1; // [RULE_19] [RULE_18]
			end else if (rd_hit(rd_en, rd_addr, `STATUS_TW_ADDR)) begin
				thermal_warning_flag <= 1'b0;
			end
			if (thermal_shutdown_level_hit) begin
				thermal_shutdown_flag <= 1'b1; // [RULE_18]
			end else if (res_temp_q[7:0] < thermal_warning_threshold) begin
				thermal_shutdown_flag <= 1'b0;
			end
		end
	end

	assign seq_end = (sq_state_q == SQ_NEXT) && (slot_q == `SLOT_TEMP);
	assign pick_ch = (pend_q == 2'h3) ? prio_q : pend_q[1];
	assign can_serve = !block_q && (pend_q != 2'h0) &&
		(slot_q == `SLOT_BOOST_A || slot_q == `SLOT_BOOST_B);

	// Sequencer: boost, supply, boost, temperature, 8 us each
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slot_q <= `SLOT_BOOST_A;
			sq_state_q <= SQ_START;
			slot_cnt_q <= 8'h00;
			adc_mux_sel <= `MUX_BOOST;
			adc_start <= 1'b0;
			pend_q <= 2'h0;
			prio_q <= 1'b0;
			serve_active_q <= 1'b0;
			serve_ch_q <= 1'b0;
			serve_on_q <= 1'b0;
			block_q <= 1'b0;
			seq_cnt_q <= 9'h000;
			forced_q <= 1'b0;
			res_supply_q <= 9'h100;
			res_boost_q <= 9'h100;
			res_temp_q <= 9'h100;
			res_on_q[0] <= 9'h100;
			res_on_q[1] <= 9'h100;
			res_str_q[0] <= 9'h100;
			res_str_q[1] <= 9'h100;
		end else begin
			adc_start <= 1'b0;
			// Falling delayed dimming level requests a string-on sample [RULE_11]
			pend_q <= pend_q | dim_fall | {2{forced_q}};
			case (sq_state_q)
				SQ_START: begin
					if (can_serve && !serve_active_q) begin
						serve_active_q <= 1'b1;
						serve_ch_q <= pick_ch;
						serve_on_q <= ctl_q[pick_ch]; // [RULE_12]
						adc_mux_sel <= pick_ch ? `MUX_STR2 : `MUX_STR1;
						pend_q[pick_ch] <= 1'b0;
						prio_q <= ~pick_ch; // [RULE_14]
						block_q <= 1'b1; // [RULE_13]
						forced_q <= 1'b0;
					end else begin
						case (slot_q)
							`SLOT_SUPPLY: adc_mux_sel <= `MUX_SUPPLY;
							`SLOT_TEMP: adc_mux_sel <= `MUX_TEMP;
							default: adc_mux_sel <= `MUX_BOOST;
						endcase
					end
					adc_start <= 1'b1; // [RULE_07] [RULE_08]
					slot_cnt_q <= 8'h00;
					sq_state_q <= SQ_WAIT;
				end
				SQ_WAIT: begin
					// Start and next states take a cycle each, so a slot is SLOT_CYC long
					if (slot_cnt_q != SLOT_CYC - 3) begin
						slot_cnt_q <= slot_cnt_q + 8'h01; // [RULE_09]
					end
					// Results stored only on completion; reads see last one
					if (adc_done) begin
						if (serve_active_q) begin
							res_str_q[serve_ch_q] <= with_parity(adc_result); // [RULE_12]
							if (serve_on_q) begin
								res_on_q[serve_ch_q] <= with_parity(adc_result);
							end
						end else begin
							case (slot_q)
								`SLOT_SUPPLY: res_supply_q <= with_parity(adc_result); // [RULE_16]
								`SLOT_TEMP: res_temp_q <= with_parity(adc_result);
								default: res_boost_q <= with_parity(adc_result); // [RULE_17]
							endcase
						end
					end
					if (slot_cnt_q == SLOT_CYC - 3) begin
						sq_state_q <= SQ_NEXT;
					end
				end
				SQ_NEXT: begin
					if (serve_active_q) begin
						serve_active_q <= 1'b0;
					end else begin
						slot_q <= slot_q + 2'h1;
					end
					if (seq_end && !serve_active_q) begin
						block_q <= 1'b0; // [RULE_13]
						// Forced sample every interval sequences [RULE_10]
						if (forced_sample_interval != 9'h000) begin
							if (seq_cnt_q + 9'h001 >= forced_sample_interval) begin
								seq_cnt_q <= 9'h000;
								forced_q <= 1'b1;
							end else begin
								seq_cnt_q <= seq_cnt_q + 9'h001;
							end
						end else begin
							seq_cnt_q <= 9'h000;
						end
					end
					sq_state_q <= SQ_START;
				end
				default: sq_state_q <= SQ_START;
			endcase
		end
	end

	// Register read port; reads have no side effect on sequencing
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 9'h000;
		end else if (rd_en) begin
			case (rd_addr)
				`ADDR_SUPPLY: rd_data <= res_supply_q;
				`ADDR_BOOST: rd_data <= res_boost_q;
				`ADDR_TEMP: rd_data <= res_temp_q;
				`ADDR_ON1: rd_data <= res_on_q[0];
				`ADDR_ON2: rd_data <= res_on_q[1];
				`ADDR_STR1: rd_data <= res_str_q[0];
				`ADDR_STR2: rd_data <= res_str_q[1];
				`STATUS_OC_ADDR: rd_data <= {7'h00, overcurrent_latched_flag};
				`STATUS_TW_ADDR: rd_data <= {7'h00, thermal_shutdown_flag, thermal_warning_flag};
				default: rd_data <= 9'h000;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- rtl/buck_protect_dim_adc_regs.vh ----
// Constants for the buck protection, dimming and converter sequencer block
// Behaviour
// RULE_01: Over-limit periods counted up to persist count plus one
// RULE_02: Counter clears below limit, disabled, dimming start
// RULE_03: Reached count holds buck off until flag read
// RULE_04: Reading latched flag re-enables the buck channel
// RULE_05: Buck enable follows control input delayed 5.5 us
// RULE_06: Controller dims at constant frequency above 300 Hz
// RULE_07: Eight-bit converter samples boost, supply, temperature, strings
// RULE_08: Sequencer autonomous; reads return last result undisturbed
// RULE_09: 8 us slots, boost every 16 us, sequence 32 us
// RULE_10: Nonzero interval forces string samples every interval sequences
// RULE_11: Buck enable falling edge requests string-on sample
// RULE_12: Input high updates both string registers, else plain
// RULE_13: One channel served per full sequence
// RULE_14: Priority starts at channel one and toggles when served
// RULE_15: Every result carries odd parity in bit 8
// RULE_16: Supply code scaled 4/255 volt per code
// RULE_17: Boost code scaled 70/255 volt per code
// RULE_18: Temperature code used for warning and shutdown
// RULE_19: Warning flag latches when temperature reaches threshold
// RULE_20: Overcurrent latches flag in status 0x13, disables buck
// RULE_21: Two-bit persist count gives one to four periods
`ifndef BUCK_PROTECT_DIM_ADC_REGS_VH
`define BUCK_PROTECT_DIM_ADC_REGS_VH
`define CLK_MHZ 25
`define DIM_DELAY_NS 5500
`define DIM_DELAY_CYC ((`DIM_DELAY_NS * `CLK_MHZ) / 1000)
`define SLOT_NS 8000
`define SLOT_CYC ((`SLOT_NS * `CLK_MHZ) / 1000)
`define STATUS_OC_ADDR 8'h13
`define STATUS_TW_ADDR 8'h14
`define ADDR_SUPPLY 8'h20
`define ADDR_BOOST 8'h21
`define ADDR_TEMP 8'h22
`define ADDR_ON1 8'h23
`define ADDR_ON2 8'h24
`define ADDR_STR1 8'h25
`define ADDR_STR2 8'h26
`define OC_FLAG1_BIT 0
`define OC_FLAG2_BIT 1
`define TW_FLAG_BIT 0
`define TW_THR_RESET 8'hB3
`define SLOT_BOOST_A 2'h0
`define SLOT_SUPPLY 2'h1
`define SLOT_BOOST_B 2'h2
`define SLOT_TEMP 2'h3
`define MUX_BOOST 3'h0
`define MUX_SUPPLY 3'h1
`define MUX_TEMP 3'h2
`define MUX_STR1 3'h3
`define MUX_STR2 3'h4
`endif

// ---- rtl/dim_delay_line.v ----
// Fixed delay from a synchronised dimming input to the buck enable
`timescale 1ns/100ps
`default_nettype none
`include "buck_protect_dim_adc_regs.vh"
module dim_delay_line #(
	parameter DELAY_CYC = `DIM_DELAY_CYC
) (
	input wire clk,
	input wire rst_n,
	input wire level_in,
	output reg level_out
);
	reg [DELAY_CYC-1:0] shift_q;

	// Shift register delays both edges equally so duty is kept
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= {DELAY_CYC{1'b0}};
			level_out <= 1'b0;
		end else begin
			shift_q <= {shift_q[DELAY_CYC-2:0], level_in}; // [RULE_05]
			level_out <= shift_q[DELAY_CYC-1];
		end
	end
endmodule
`default_nettype wire

// ---- testbench/adc_model.sv ----
// Behavioural converter answering each start strobe with one result
`timescale 1ns/100ps
`default_nettype none
module adc_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic adc_start,
	input wire logic [7:0] code,
	input wire logic [7:0] lat,
	output logic adc_done,
	output logic [7:0] adc_result
);
	int cnt;
	// Count down from the strobe, show the code for one cycle, else scramble it
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			adc_done <= 1'b0;
			adc_result <= 8'h00;
		end else begin
			adc_done <= (cnt == 1);
			adc_result <= (cnt == 1) ? code : ~adc_result;
			if (adc_start)
				cnt <= int'(lat);
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
	end
endmodule
`default_nettype wire

// ---- testbench/buck_protect_dim_adc_checker.sv ----
// Port assertions for the protection, dimming and converter sequencer
`timescale 1ns/100ps
`default_nettype none
module buck_protect_dim_adc_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] dimming_control_input,
	input wire logic [1:0] buck_period_pulse,
	input wire logic [7:0] thermal_warning_threshold,
	input wire logic [2:0] adc_mux_sel,
	input wire logic adc_start,
	input wire logic adc_done,
	input wire logic [7:0] adc_result,
	input wire logic rd_en,
	input wire logic [7:0] rd_addr,
	input wire logic [8:0] rd_data,
	input wire logic [1:0] buck_enable,
	input wire logic [1:0] overcurrent_latched_flag,
	input wire logic thermal_warning_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Converter slots: one-cycle strobe, fixed 200-cycle spacing
	property p_strobe; adc_start |=> !adc_start [*8]; endproperty
	a_strobe: assert property (p_strobe) else $error("strobe too long");
	property p_slot; $past(adc_start, 200) |-> adc_start; endproperty
	a_slot: assert property (p_slot) else $error("slot length wrong");
	// Read answers
	property p_parity; rd_en && rd_addr inside {[8'h20:8'h26]} |=> ^rd_data; endproperty
	a_parity: assert property (p_parity) else $error("parity not odd");
	property p_unmapped; rd_en && rd_addr == 8'hF0 |=> rd_data == 9'h000; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
	// Overcurrent hold and release
	property p_oc_hold; overcurrent_latched_flag[0] |=> !overcurrent_latched_flag[0] || !buck_enable[0]; endproperty
	a_oc_hold: assert property (p_oc_hold) else $error("buck on while tripped");
	property p_oc_clr; rd_en && rd_addr == 8'h13 && buck_period_pulse == 2'b00 |=> overcurrent_latched_flag == 2'b00; endproperty
	a_oc_clr: assert property (p_oc_clr) else $error("flag not cleared");
	// Dimming delay and thermal warning
	property p_dim; $fell(buck_enable[1]) |-> !$past(dimming_control_input[1], 130) && $past(dimming_control_input[1], 150); endproperty
	a_dim: assert property (p_dim) else $error("dimming delay wrong");
	property p_warn; adc_done && adc_mux_sel == 3'h2 && adc_result >= thermal_warning_threshold |-> ##[1:3] thermal_warning_flag; endproperty
	a_warn: assert property (p_warn) else $error("warning not set");
endmodule
bind buck_protect_dim_adc buck_protect_dim_adc_checker i_chk (
	.clk(clk),
	.rst_n(rst_n),
	.dimming_control_input(dimming_control_input),
	.buck_period_pulse(buck_period_pulse),
	.thermal_warning_threshold(thermal_warning_threshold),
	.adc_mux_sel(adc_mux_sel),
	.adc_start(adc_start),
	.adc_done(adc_done),
	.adc_result(adc_result),
	.rd_en(rd_en),
	.rd_addr(rd_addr),
	.rd_data(rd_data),
	.buck_enable(buck_enable),
	.overcurrent_latched_flag(overcurrent_latched_flag),
	.thermal_warning_flag(thermal_warning_flag)
);
`default_nettype wire

// ---- testbench/buck_protect_dim_adc_bench.sv ----
// Self-checking bench for the protection, dimming and converter sequencer
`timescale 1ns/100ps
`default_nettype none
module buck_protect_dim_adc_bench;
	logic clk = 1'b0, rst_n = 1'b0, rd_en = 1'b0, thermal_shutdown_level_hit = 1'b0;
	logic [1:0] dimming_control_input = 2'b11, channel_enable = 2'b11, buck_period_pulse = 2'b00;
	logic [1:0] over_limit = 2'b00, overcurrent_persist_count = 2'b00;
	logic [8:0] forced_sample_interval = 9'h001;
	logic [7:0] thermal_warning_threshold = 8'h80, rd_addr = 8'h00, code = 8'h5A, lat = 8'h10;
	logic [2:0] adc_mux_sel;
	logic adc_start, adc_done, thermal_warning_flag, thermal_shutdown_flag;
	logic [7:0] adc_result;
	logic [8:0] rd_data;
	logic [1:0] buck_enable, overcurrent_latched_flag;
	logic [8:0] exp_q [7];
	int err_count = 0;
	int checks_done = 0;
	int seed = 12;
	int nstr = 0;
	int i, p, k, ix;
	logic hot;
	always #20 clk = ~clk;
	buck_protect_dim_adc #(
		.PERSIST_W(2)
	) i_dut (
		.clk(clk),
		.rst_n(rst_n),
		.dimming_control_input(dimming_control_input),
		.channel_enable(channel_enable),
		.buck_period_pulse(buck_period_pulse),
		.over_limit(over_limit),
		.overcurrent_persist_count(overcurrent_persist_count),
		.forced_sample_interval(forced_sample_interval),
		.thermal_warning_threshold(thermal_warning_threshold),
		.thermal_shutdown_level_hit(thermal_shutdown_level_hit),
		.adc_mux_sel(adc_mux_sel),
		.adc_start(adc_start),
		.adc_done(adc_done),
		.adc_result(adc_result),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.buck_enable(buck_enable),
		.overcurrent_latched_flag(overcurrent_latched_flag),
		.thermal_warning_flag(thermal_warning_flag),
		.thermal_shutdown_flag(thermal_shutdown_flag)
	);
	adc_model i_adc (
		.clk(clk),
		.rst_n(rst_n),
		.adc_start(adc_start),
		.code(code),
		.lat(lat),
		.adc_done(adc_done),
		.adc_result(adc_result)
	);
	task chk(input string n, input logic [8:0] s, input logic [8:0] e);
		checks_done++;
		if (s !== e) begin
			$display("[ERR] %s expected %h seen %h", n, e, s);
			err_count++;
		end
	endtask
	task test_done;
		if (err_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk);
		rd_en <= 1'b1;
		rd_addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		@(posedge clk);
	endtask
	task pulse;
		@(posedge clk);
		buck_period_pulse <= 2'b01;
		@(posedge clk);
		buck_period_pulse <= 2'b00;
		repeat (2) @(posedge clk);
	endtask
	task wait_done;
		int n;
		for (n = 0; n < 400 && adc_done !== 1'b1; n++)
			@(posedge clk);
		if (n == 400) begin
			chk("timeout", 9'h000, 9'h001);
			test_done;
		end
	endtask
	// Reference result registers, refreshed on every conversion; new random code and latency
	always @(posedge clk) begin
		if (rst_n && adc_done === 1'b1) begin
			ix = (adc_mux_sel == 3'h0) ? 1 : (adc_mux_sel == 3'h1) ? 0 :
				(adc_mux_sel == 3'h2) ? 2 : int'(adc_mux_sel) + 2;
			exp_q[ix] = {~^adc_result, adc_result};
			if (adc_mux_sel > 3'h2) begin
				nstr++;
				if (dimming_control_input[adc_mux_sel - 3'h3])
					exp_q[ix - 2] = {~^adc_result, adc_result};
			end
			code <= 8'($random(seed));
			lat <= {1'b0, 7'($random(seed))} + 8'h01;
		end
	end
	initial begin
		foreach (exp_q[j])
			exp_q[j] = 9'h100;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (200) @(posedge clk);
		// Trip after count plus one periods; a period below the limit restarts the count
		for (p = 0; p < 4; p++) begin
			overcurrent_persist_count <= 2'(p);
			over_limit <= 2'b01;
			repeat (p) pulse;
			over_limit <= 2'b00;
			pulse;
			over_limit <= 2'b01;
			repeat (p) pulse;
			chk("oc early", 9'(overcurrent_latched_flag), 9'h000);
			pulse;
			chk("oc flag", 9'(overcurrent_latched_flag), 9'h001);
			chk("buck off", 9'(buck_enable[0]), 9'h000);
			over_limit <= 2'b00;
			rd(8'h13);
			chk("oc status", 9'(rd_data[1:0]), 9'h001);
			repeat (3) @(posedge clk);
			chk("oc clear", 9'(overcurrent_latched_flag), 9'h000);
			chk("buck on", 9'(buck_enable[0]), 9'h001);
		end
		// Disabling the channel restarts the count
		overcurrent_persist_count <= 2'h1;
		over_limit <= 2'b01;
		pulse;
		channel_enable <= 2'b10;
		@(posedge clk);
		channel_enable <= 2'b11;
		pulse;
		chk("oc disable", 9'(overcurrent_latched_flag), 9'h000);
		over_limit <= 2'b00;
		// Channel two buck follows its input after the fixed delay; change it just after a result
		wait_done;
		dimming_control_input[1] <= 1'b0;
		repeat (130) @(posedge clk);
		chk("dim early", 9'(buck_enable[1]), 9'h001);
		repeat (20) @(posedge clk);
		chk("dim late", 9'(buck_enable[1]), 9'h000);
		// Every stored result against the reference, reads interleaved with conversions
		nstr = 0;
		for (i = 0; i < 40; i++) begin
			wait_done;
			repeat (2) @(posedge clk);
			for (k = 0; k < 7; k++) begin
				rd(8'h20 + 8'(k));
				chk("result", rd_data, exp_q[k]);
			end
		end
		rd(8'hF0);
		chk("unmapped", rd_data, 9'h000);
		chk("forced", 9'(nstr > 4 && nstr < 12), 9'h001);
		// Zero interval stops forced string samples
		forced_sample_interval <= 9'h000;
		repeat (1600) @(posedge clk);
		nstr = 0;
		repeat (3200) @(posedge clk);
		chk("no forced", 9'(nstr), 9'h000);
		// Shutdown holds both bucks off and clears below the warning level; a read clears the warning
		thermal_warning_threshold <= 8'h00;
		repeat (3) @(posedge clk);
		chk("tw set", 9'(thermal_warning_flag), 9'h001);
		thermal_warning_threshold <= 8'hFF;
		thermal_shutdown_level_hit <= 1'b1;
		repeat (3) @(posedge clk);
		chk("tsd on", {6'h00, thermal_shutdown_flag, buck_enable}, 9'h004);
		thermal_shutdown_level_hit <= 1'b0;
		repeat (3) @(posedge clk);
		hot = (exp_q[2][7:0] == 8'hFF);
		chk("tsd off", {6'h00, thermal_shutdown_flag, buck_enable}, {6'h00, hot, 1'b0, ~hot});
		rd(8'h14);
		chk("tw status", 9'(rd_data[1:0]), {7'h00, hot, 1'b1});
		rd(8'h14);
		chk("tw clear", 9'(rd_data[0]), {8'h00, hot});
		test_done;
	end
endmodule
`default_nettype wire
